// file: core/itm_interval_timer.sv
// top: 16-bit interval timer with compare register and interrupt
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - A 16-bit up-counter runs on the selected count clock and software cannot read or write it.
// - The compare register is 16 bits and is accessed only as a whole 16-bit word.
// - Reset loads the compare register with zero.
// - Rewriting the compare register with its present value is harmless at any time.
// - The control register is 8 bits and takes whole-byte or single-bit writes.
// - Reset clears the control register, so the timer is stopped on the undivided clock.
// - Rewriting the control register with its present value is harmless at any time.
// - While the run bit 7 is zero the timer is disabled and its counter is held at all ones at once.
// - Setting the run bit starts the count clock and counting.
// - On start the counter goes from all ones to zero on the first count clock, then counts up.
// - On a match with the compare value the counter clears and a compare-match request is raised.
module itm_interval_timer
   import itm_pkg::*;
(
   input wire logic mclk_in,             // base clock, 250 MHz
   input wire logic reset_n_in,          // async reset, active low
   input wire logic [ADDR_W-1:0] addr_in, // register byte address
   input wire logic [31:0] wdata_in,     // write data
   input wire logic wr_in,               // write strobe
   input wire logic rd_in,               // read strobe
   input wire logic [7:0] bit_en_in,     // control bit enables, all ones for byte write
   output logic [31:0] rdata_out,        // read data, cycle after strobe
   output logic compare_match_irq_out,   // compare-match pulse, one cycle per match; stays high with compare zero on /1
   output logic irq_out                  // level interrupt
);
   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   logic [15:0] compare_reg;
   logic [7:0] control_reg;
   logic [7:0] control_next;
   logic status_reg;
   logic mask_reg;
   logic wr_cmp;
   logic wr_ctl;
   logic wr_sts;
   logic wr_msk;
   logic timer_run_enable;
   logic [2:0] count_clock_select;
   logic [7:0] ctl_bits;

   assign wr_cmp = wr_in && (addr_in == COMPARE_ADDR);
   assign wr_ctl = wr_in && (addr_in == CONTROL_ADDR);
   assign wr_sts = wr_in && (addr_in == IRQ_STATUS_ADDR);
   assign wr_msk = wr_in && (addr_in == IRQ_MASK_ADDR);
   // bits 3..6 held at zero whatever software writes
   assign ctl_bits = (control_reg & ~bit_en_in) | (wdata_in[7:0] & bit_en_in);
   assign control_next = ctl_bits & CONTROL_WMASK;
   assign timer_run_enable = control_reg[RUN_BIT];
   assign count_clock_select = control_reg[SEL_HI:0];

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         compare_reg <= COMPARE_RESET;
         control_reg <= CONTROL_RESET;
         mask_reg <= 1'b0;
      end else begin
         // same-value writes change nothing downstream
         if (wr_cmp) begin
            compare_reg <= wdata_in[15:0];
         end
         if (wr_ctl) begin
            control_reg <= control_next;
         end
         if (wr_msk) begin
            mask_reg <= wdata_in[0];
         end
      end
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   logic tick;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic match;
   logic counter_rst_n;
   logic started_reg;

   itm_prescaler u_prescaler (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .run_in(timer_run_enable),
      .sel_in(count_clock_select),
      .tick_out(tick)
   );

   // the first tick only wraps the stopped all-ones value, so no match then,
   // even with a compare value of all ones
   assign match = started_reg && (count_reg == compare_reg);
   assign count_next = (match || !started_reg) ? COUNT_ZERO : count_reg + COUNT_ONE;
   // clearing run resets the counter without a clock edge; both inputs of
   // the and are flip-flops, so the clear only pulses on a real change
   assign counter_rst_n = rst_n && timer_run_enable;

   always_ff @(posedge mclk_in or negedge counter_rst_n) begin
      if (!counter_rst_n) begin
         count_reg <= COUNT_STOPPED;
         started_reg <= 1'b0;
      end else if (tick) begin
         count_reg <= count_next;
         started_reg <= 1'b1;
      end
   end

   logic match_evt;
   assign match_evt = tick && match;
   assign compare_match_irq_out = match_evt;

   // ----------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= 1'b0;
      end else if (match_evt) begin
         status_reg <= 1'b1; // set wins over a clear in the same cycle
      end else if (wr_sts && wdata_in[0]) begin
         status_reg <= 1'b0;
      end
   end

   assign irq_out = status_reg && mask_reg;

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   logic [31:0] rsel;

   assign rsel = (addr_in == COMPARE_ADDR) ? {16'h0000, compare_reg} :
                 (addr_in == CONTROL_ADDR) ? {24'h000000, control_reg} :
                 (addr_in == IRQ_STATUS_ADDR) ? {31'h00000000, status_reg} :
                 (addr_in == IRQ_MASK_ADDR) ? {31'h00000000, mask_reg} : READ_ZERO;

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_out <= READ_ZERO;
      end else begin
         rdata_out <= rd_in ? rsel : READ_ZERO;
      end
   end
endmodule
`default_nettype wire

// file: core/itm_pkg.sv
// package: register map, field layout and constants of the interval timer
package itm_pkg;
   localparam int ADDR_W = 32;
   localparam logic [ADDR_W-1:0] COMPARE_ADDR = 32'hfffff544;
   localparam logic [ADDR_W-1:0] CONTROL_ADDR = 32'hfffff540;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 32'hfffff548;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 32'hfffff54c;
   localparam logic [15:0] COMPARE_RESET = 16'h0000;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam int RUN_BIT = 7;
   localparam int SEL_HI = 2;
   localparam logic [7:0] CONTROL_WMASK = 8'h87;
   localparam logic [15:0] COUNT_STOPPED = 16'hffff;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [6:0] PRESCALE_ZERO = 7'h00;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [6:0] PRESCALE_ONE = 7'h01;
   localparam logic [31:0] READ_ZERO = 32'h00000000;
endpackage

// file: core/itm_prescaler.sv
// prescaler: divides the base clock and produces one-cycle count ticks
`timescale 1ns/10ps
`default_nettype none
module itm_prescaler
   import itm_pkg::*;
(
   input wire logic clk_in,        // base clock
   input wire logic rst_n_in,      // synchronised reset
   input wire logic run_in,        // run enable, low stops ticks at once and clears the divider on the next clock
   input wire logic [2:0] sel_in,  // divide select
   output logic tick_out           // one-cycle count clock tick
);
   logic [6:0] div_reg;
   logic [6:0] div_next;
   logic [6:0] div_mask;
   logic [7:0] mask_wide;

   assign mask_wide = (8'h01 << sel_in) - 8'h01;
   assign div_mask = mask_wide[6:0];
   assign div_next = ((div_reg & div_mask) == div_mask) ? PRESCALE_ZERO : div_reg + PRESCALE_ONE;
   // tick on the last base cycle of each period; /1 ticks every cycle
   assign tick_out = run_in && ((div_reg & div_mask) == div_mask);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_reg <= PRESCALE_ZERO;
      end else if (!run_in) begin
         div_reg <= PRESCALE_ZERO;
      end else begin
         div_reg <= div_next;
      end
   end
endmodule
`default_nettype wire

// file: tb/itm_interval_timer_properties.sv
// checker: port-level properties of the interval timer
`timescale 1ns/10ps
`default_nettype none
module itm_interval_timer_properties
   import itm_pkg::*;
(
   input wire logic mclk_in, // clock
   input wire logic reset_n_in, // reset
   input wire logic [ADDR_W-1:0] addr_in, // address
   input wire logic [31:0] wdata_in, // write data
   input wire logic wr_in, // write strobe
   input wire logic rd_in, // read strobe
   input wire logic [7:0] bit_en_in, // bit enables
   input wire logic [31:0] rdata_out, // read data
   input wire logic compare_match_irq_out, // match pulse
   input wire logic irq_out // interrupt
);
   wire logic mapped = addr_in inside {COMPARE_ADDR, CONTROL_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR};
   wire logic stop_wr = wr_in && addr_in == CONTROL_ADDR && bit_en_in[RUN_BIT] && !wdata_in[RUN_BIT];
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   a_rdata_idle: assert property (!rd_in |=> rdata_out == READ_ZERO) else $error("read data not idle");
   a_ctl_read: assert property (rd_in && addr_in == CONTROL_ADDR |=> rdata_out[31:8] == 0 && rdata_out[6:3] == 0)
      else $error("control read has stray bits");
   a_cmp_read: assert property (rd_in && addr_in == COMPARE_ADDR |=> rdata_out[31:16] == 0) else $error("compare wide");
   a_unmapped_zero: assert property (rd_in && !mapped |=> rdata_out == 0) else $error("unmapped read not zero");
   a_stop_quiet: assert property (stop_wr |=> !compare_match_irq_out [*3]) else $error("match while stopped");
   a_mask_off: assert property (wr_in && addr_in == IRQ_MASK_ADDR && !wdata_in[0] |=> !irq_out) else $error("mask");
   a_irq_rise: assert property ($rose(irq_out) |-> $past(compare_match_irq_out) || $past(wr_in))
      else $error("interrupt rose without cause");
   a_irq_fall: assert property ($fell(irq_out) |-> $past(wr_in)) else $error("interrupt fell without write");
endmodule
`default_nettype wire

// file: tb/itm_interval_timer_tb_top.sv
// testbench: drives the timer registers and compares with a model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t %h %h", $time, a, b); end end
module itm_interval_timer_tb_top import itm_pkg::*; ();
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [ADDR_W-1:0] addr_in = '0;
   logic [31:0] wdata_in = '0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] bit_en_in = 8'hff;
   logic [31:0] rdata_out;
   logic compare_match_irq_out;
   logic irq_out;
   logic [ADDR_W-1:0] ra [5] = '{COMPARE_ADDR, CONTROL_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR, 32'hfffff550};
   int error_cnt = 0;
   int num_checks = 0;
   int seed = 16807;
   int cycles = 0;
   // register model kept from the rules; reads queue their expectation
   int m_cmp = 0;
   int m_ctl = 0;
   int m_sts = 0;
   int m_msk = 0;
   int exp_q[$];
   function automatic int mdl_rd(input logic [ADDR_W-1:0] a);
      if (a == COMPARE_ADDR) return m_cmp;
      if (a == CONTROL_ADDR) return m_ctl;
      if (a == IRQ_STATUS_ADDR) return m_sts;
      if (a == IRQ_MASK_ADDR) return m_msk;
      return 0;
   endfunction
   itm_interval_timer dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .bit_en_in(bit_en_in), .rdata_out(rdata_out),
      .compare_match_irq_out(compare_match_irq_out), .irq_out(irq_out));
   initial begin
      forever #2 mclk_in = ~mclk_in;
   end
   // ----------------------------------------
   // bus tasks and verdict
   // ----------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [7:0] be);
      @(posedge mclk_in);
      if (a == COMPARE_ADDR) m_cmp = v & 32'hffff;
      if (a == CONTROL_ADDR) m_ctl = ((m_ctl & ~be) | (v & be)) & 32'h87;
      if (a == IRQ_STATUS_ADDR && v[0]) m_sts = 0;
      if (a == IRQ_MASK_ADDR) m_msk = v & 1;
      addr_in <= a;
      wdata_in <= v;
      bit_en_in <= be;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
      int e;
      @(posedge mclk_in);
      exp_q.push_back(mdl_rd(a));
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
      e = exp_q.pop_front();
      `CHK(v, e)
   endtask
   // pulse is one cycle wide except with compare zero on /1, so sample every cycle
   task automatic wait_pulse(output int c);
      c = 0;
      do begin
         @(posedge mclk_in);
         #1 c++;
      end while (compare_match_irq_out !== 1'b1 && c < 20000);
      if (compare_match_irq_out === 1'b1) m_sts = 1;
   endtask
   initial begin
      logic [31:0] v;
      int n, d, e_cmp;
      repeat (12) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      foreach (ra[i]) begin
         rd(ra[i], v);
         `CHK(v, 32'h0)
      end
      $display("test 1 done");
      wr(CONTROL_ADDR, 32'h07, 8'hff);
      wr(CONTROL_ADDR, 32'h0, 8'h02);
      rd(CONTROL_ADDR, v);
      `CHK(v, 32'h05)
      e_cmp = $random(seed);
      wr(COMPARE_ADDR, e_cmp, 8'hff);
      rd(COMPARE_ADDR, v);
      `CHK(v, e_cmp & 32'hffff)
      $display("test 2 done");
      for (int s = 0; s < 8; s++) begin
         n = (s == 0) ? 0 : ($random(seed) & 3);
         wr(COMPARE_ADDR, n, 8'hff);
         wr(IRQ_MASK_ADDR, 1, 8'hff);
         wr(CONTROL_ADDR, 32'h80 | s, 8'hff);
         // n+2 count clocks, the pulse seen in the last base cycle of them
         wait_pulse(d);
         `CHK(d, ((n + 2) << s) - 1)
         wr(COMPARE_ADDR, n, 8'hff);
         wr(CONTROL_ADDR, 32'h80 | s, 8'hff);
         wait_pulse(d);
         wait_pulse(d);
         `CHK(d, (n + 1) << s)
         `CHK(irq_out, 1'b1)
         wr(CONTROL_ADDR, s, 8'hff);
         wr(IRQ_MASK_ADDR, 0, 8'hff);
         rd(IRQ_STATUS_ADDR, v);
         `CHK(v, 32'h1)
         wr(IRQ_STATUS_ADDR, 1, 8'hff);
         rd(IRQ_STATUS_ADDR, v);
         `CHK(v, 32'h0)
         $display("test %0d done", s + 3);
      end
      print_verdict();
   end
endmodule
bind itm_interval_timer itm_interval_timer_properties u_props (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .bit_en_in(bit_en_in),
   .rdata_out(rdata_out), .compare_match_irq_out(compare_match_irq_out), .irq_out(irq_out));
`default_nettype wire
